// ==== src/ssm_pkg.sv ====
// Purpose: shared constants of the synchronous serial master port
// Assumes: classic wishbone slave, 8-bit registers in the low lane
// Notes:   register offsets are byte addresses, one word each

package ssm_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int         ADR_W         = 5;
  localparam logic [4:0] OFF_RCV_STAT  = 5'h00;
  localparam logic [4:0] OFF_TX_HOLD   = 5'h04;
  localparam logic [4:0] OFF_TX_STAT   = 5'h08;
  localparam logic [4:0] OFF_BAUD_POL  = 5'h0c;
  localparam logic [4:0] OFF_DIV_HI    = 5'h10;
  localparam logic [4:0] OFF_DIV_LO    = 5'h14;
  localparam logic [4:0] OFF_RX_FIFO   = 5'h18;
  localparam logic [4:0] OFF_FLAGS     = 5'h1c;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int RCV_PORT_EN    = 7;
  localparam int RCV_NINE       = 6;
  localparam int RCV_SINGLE     = 5;
  localparam int RCV_CONT       = 4;
  localparam int RCV_OVERRUN    = 1;
  localparam int RCV_NINTH      = 0;
  localparam int TX_CLK_MASTER  = 7;
  localparam int TX_NINE        = 6;
  localparam int TX_ENABLE      = 5;
  localparam int TX_SYNC_MODE   = 4;
  localparam int TX_HIGH_SPEED  = 2;
  localparam int TX_SHIFT_IDLE  = 1;
  localparam int TX_NINTH       = 0;
  localparam int BP_DATA_INV    = 5;
  localparam int BP_CLK_IDLE    = 4;
  localparam int BP_WIDE_DIV    = 3;
  localparam int FL_RX_PENDING  = 1;
  localparam int FL_TX_EMPTY    = 0;
  // ---------------------------------------------------------------
  // reset values and counts
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_RCV_STAT  = 8'h00;
  localparam logic [7:0] RST_TX_STAT   = 8'h00;
  localparam logic [7:0] RST_BAUD_POL  = 8'h00;
  localparam logic [7:0] RST_DIV       = 8'h00;
  localparam logic [5:0] PRE_HALF_SLOW = 6'h20;
  localparam logic [5:0] PRE_HALF_MID  = 6'h08;
  localparam logic [5:0] PRE_HALF_FAST = 6'h02;
  localparam logic [3:0] CHAR_BITS_STD = 4'h8;
  localparam logic [3:0] CHAR_BITS_9   = 4'h9;
  localparam int         FIFO_DEPTH    = 2;
endpackage : ssm_pkg

// ==== src/ssm_brg.sv ====
// Purpose: divider that paces the master shift clock in half periods
// Assumes: run_i low holds the divider at its start
// Notes:   half period is prescale times (divisor plus one) clocks
`timescale 1ns/1ps
`default_nettype none

module ssm_brg #(
  parameter int DIV_W = 16
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic             baud_wide_divisor_select_i,
  input  wire logic             baud_high_speed_select_i,
  input  wire logic [DIV_W-1:0] div_i,
  output logic                  half_tick_o
);
  import ssm_pkg::*;

  logic [5:0]       pre_lim;
  logic [5:0]       pre_q;
  logic [DIV_W-1:0] div_q;
  logic [DIV_W-1:0] div_lim;
  logic             pre_wrap;

  always_comb begin
    case ({baud_wide_divisor_select_i, baud_high_speed_select_i})
      2'b00:   pre_lim = PRE_HALF_SLOW;
      2'b11:   pre_lim = PRE_HALF_FAST;
      default: pre_lim = PRE_HALF_MID;
    endcase
  end

  // narrow divisor uses only the low byte
  assign div_lim  = baud_wide_divisor_select_i ? div_i : {{(DIV_W-8){1'b0}}, div_i[7:0]};
  assign pre_wrap = (pre_q == pre_lim - 6'h01);

  always_ff @(posedge clk_i) begin
    if (rst_i || !run_i) begin
      pre_q <= 6'h00;
      div_q <= '0;
    end else if (pre_wrap) begin
      pre_q <= 6'h00;
      div_q <= (div_q == div_lim) ? '0 : div_q + 1'b1;
    end else begin
      pre_q <= pre_q + 6'h01;
    end
  end

  assign half_tick_o = run_i && pre_wrap && (div_q == div_lim);
endmodule : ssm_brg

`default_nettype wire

// ==== src/ssm_port.sv ====
// Purpose: synchronous half-duplex serial port, master and slave clocking
// Assumes: classic wishbone, one word per register, data in low byte
// Notes:   pins are sampled through two flops; slave clock edges are
//          found by oversampling, so the link must be much slower
`timescale 1ns/1ps
`default_nettype none

module ssm_port #(
  parameter int DIV_W = 16
) (
  input  wire logic                      clk_i,
  input  wire logic                      rst_i,
  input  wire logic                      wb_cyc_i,
  input  wire logic                      wb_stb_i,
  input  wire logic                      wb_we_i,
  input  wire logic [ssm_pkg::ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]                wb_sel_i,
  input  wire logic [31:0]               wb_dat_i,
  output logic      [31:0]               wb_dat_o,
  output logic                           wb_ack_o,
  input  wire logic                      ck_line_i,
  output logic                           ck_line_o,
  output logic                           ck_line_oe_o,
  input  wire logic                      dt_line_i,
  output logic                           dt_line_o,
  output logic                           dt_line_oe_o
);
  import ssm_pkg::*;

  localparam int CNT_W = $clog2(FIFO_DEPTH + 1);
  localparam int PTR_W = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;

  function automatic logic hit(input logic [ADR_W-1:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  // ---------------------------------------------------------------
  // register bus
  // ---------------------------------------------------------------
  logic       ack_q;
  logic       acc;
  logic       wr_lo;
  logic [7:0] wbyte;
  logic [31:0] rd_d;
  logic [31:0] rd_q;

  assign acc   = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr_lo = acc && wb_we_i && wb_sel_i[0];
  assign wbyte = wb_dat_i[7:0];

  always_ff @(posedge clk_i) begin
    if (rst_i) ack_q <= 1'b0;
    else       ack_q <= acc;
  end

  // control bits
  logic port_en_q, rx_nine_q, srx_en_q, crx_en_q;
  logic clk_master_q, tx_nine_q, tx_en_q, sync_mode_q, high_speed_q, tx_ninth_q;
  logic data_inv_q, clk_idle_q, wide_div_q;
  logic [7:0] div_hi_q, div_lo_q;
  logic rx_done;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {port_en_q, rx_nine_q, srx_en_q, crx_en_q} <= RST_RCV_STAT[7:4];
    end else if (wr_lo && hit(wb_adr_i, OFF_RCV_STAT)) begin
      port_en_q <= wbyte[RCV_PORT_EN];
      rx_nine_q <= wbyte[RCV_NINE];
      srx_en_q  <= wbyte[RCV_SINGLE];
      crx_en_q  <= wbyte[RCV_CONT];
    end else if (rx_done && srx_en_q) begin
      srx_en_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {clk_master_q, tx_nine_q, tx_en_q, sync_mode_q} <= RST_TX_STAT[7:4];
      high_speed_q <= RST_TX_STAT[TX_HIGH_SPEED];
      tx_ninth_q   <= RST_TX_STAT[TX_NINTH];
    end else if (wr_lo && hit(wb_adr_i, OFF_TX_STAT)) begin
      clk_master_q <= wbyte[TX_CLK_MASTER];
      tx_nine_q    <= wbyte[TX_NINE];
      tx_en_q      <= wbyte[TX_ENABLE];
      sync_mode_q  <= wbyte[TX_SYNC_MODE];
      high_speed_q <= wbyte[TX_HIGH_SPEED];
      tx_ninth_q   <= wbyte[TX_NINTH];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_inv_q <= RST_BAUD_POL[BP_DATA_INV];
      clk_idle_q <= RST_BAUD_POL[BP_CLK_IDLE];
      wide_div_q <= RST_BAUD_POL[BP_WIDE_DIV];
      div_hi_q   <= RST_DIV;
      div_lo_q   <= RST_DIV;
    end else if (wr_lo) begin
      if (hit(wb_adr_i, OFF_BAUD_POL)) begin
        data_inv_q <= wbyte[BP_DATA_INV];
        clk_idle_q <= wbyte[BP_CLK_IDLE];
        wide_div_q <= wbyte[BP_WIDE_DIV];
      end else if (hit(wb_adr_i, OFF_DIV_HI)) begin
        div_hi_q <= wbyte;
      end else if (hit(wb_adr_i, OFF_DIV_LO)) begin
        div_lo_q <= wbyte;
      end
    end
  end

  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  logic port_on, master, tx_dir, tx_go, rx_run, overrun_error_flag_q;

  assign port_on = port_en_q && sync_mode_q;
  assign master  = port_on && clk_master_q;
  assign tx_dir  = !srx_en_q && !crx_en_q;
  assign tx_go   = port_on && tx_en_q && tx_dir;
  // overrun holds the receiver off until cleared
  assign rx_run  = port_on && !tx_dir && !overrun_error_flag_q;

  // ---------------------------------------------------------------
  // pin synchronisers and slave edge detect
  // ---------------------------------------------------------------
  logic ck_s1_q, ck_s2_q, ck_prev_q, dt_s1_q, dt_s2_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {ck_s1_q, ck_s2_q, ck_prev_q} <= 3'h0;
      {dt_s1_q, dt_s2_q}            <= 2'h0;
    end else begin
      ck_s1_q   <= ck_line_i;
      ck_s2_q   <= ck_s1_q;
      ck_prev_q <= ck_s2_q;
      dt_s1_q   <= dt_line_i;
      dt_s2_q   <= dt_s1_q;
    end
  end

  // ---------------------------------------------------------------
  // shift clock: master divider or slave edges
  // ---------------------------------------------------------------
  logic tx_busy_q, phase_q, half_tick, mst_run, lead_ev, trail_ev, sl_edge;

  assign mst_run = master && (tx_busy_q || rx_run);
  assign sl_edge = port_on && !clk_master_q && (ck_s2_q != ck_prev_q) && (tx_busy_q || rx_run);

  ssm_brg #(.DIV_W(DIV_W)) u_brg (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .run_i       (mst_run),
    .baud_wide_divisor_select_i     (wide_div_q),
    .baud_high_speed_select_i      (high_speed_q),
    .div_i       (DIV_W'({div_hi_q, div_lo_q})),
    .half_tick_o (half_tick)
  );

  // clock returns to idle the cycle after the run condition drops
  always_ff @(posedge clk_i) begin
    if (rst_i || !mst_run) phase_q <= 1'b0;
    else if (half_tick)    phase_q <= !phase_q;
  end

  // slave relies on the far master pacing one clock per bit
  assign lead_ev  = master ? (half_tick && !phase_q) : (sl_edge && ck_s2_q != clk_idle_q);
  assign trail_ev = master ? (half_tick && phase_q) : (sl_edge && ck_s2_q == clk_idle_q);

  assign ck_line_o    = clk_idle_q ^ phase_q;
  assign ck_line_oe_o = master;

  // ---------------------------------------------------------------
  // bit counter shared by both directions
  // ---------------------------------------------------------------
  logic [3:0] bitcnt_q, char_bits;
  logic       last_bit;

  assign char_bits = (tx_busy_q ? tx_nine_q : rx_nine_q) ? CHAR_BITS_9 : CHAR_BITS_STD;
  assign last_bit  = trail_ev && (bitcnt_q == char_bits - 4'h1);

  // a dropped receive enable discards the partial character
  always_ff @(posedge clk_i) begin
    if (rst_i || !(tx_busy_q || rx_run)) bitcnt_q <= 4'h0;
    else if (last_bit)                   bitcnt_q <= 4'h0;
    else if (trail_ev)                   bitcnt_q <= bitcnt_q + 4'h1;
  end

  // ---------------------------------------------------------------
  // transmit path
  // ---------------------------------------------------------------
  logic [7:0] hold_q;
  logic       hold_ninth_q, hold_full_q, tx_load, hold_wr;
  logic [8:0] shift_tx_q;
  logic       dout_q;

  assign hold_wr = wr_lo && hit(wb_adr_i, OFF_TX_HOLD);
  assign tx_load = tx_go && hold_full_q && !tx_busy_q;

  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en_q) begin
      hold_full_q  <= 1'b0;
      hold_q       <= 8'h00;
      hold_ninth_q <= 1'b0;
    end else if (hold_wr) begin
      hold_full_q  <= 1'b1;
      hold_q       <= wbyte;
      hold_ninth_q <= tx_ninth_q;
    end else if (tx_load) begin
      hold_full_q  <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en_q) begin
      tx_busy_q  <= 1'b0;
      shift_tx_q <= 9'h000;
    end else if (tx_load) begin
      tx_busy_q  <= 1'b1;
      shift_tx_q <= {hold_ninth_q, hold_q};
    end else if (tx_busy_q && trail_ev) begin
      shift_tx_q <= {1'b0, shift_tx_q[8:1]};
      if (last_bit) tx_busy_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)                      dout_q <= 1'b0;
    else if (tx_busy_q && lead_ev)  dout_q <= shift_tx_q[0];
  end

  assign dt_line_o    = dout_q ^ data_inv_q;
  assign dt_line_oe_o = tx_go;

  // ---------------------------------------------------------------
  // receive path and fifo
  // ---------------------------------------------------------------
  logic [8:0] shift_rx_q, shift_rx_d;
  logic       sample;
  logic [8:0] fifo_q [FIFO_DEPTH];
  logic [PTR_W-1:0] wr_ptr_q, rd_ptr_q;
  logic [CNT_W-1:0] count_q;
  logic       pop, push, ov_set, ovr_single_q;

  assign sample     = dt_s2_q ^ data_inv_q;
  assign shift_rx_d = rx_nine_q ? {sample, shift_rx_q[8:1]}
                                : {1'b0, sample, shift_rx_q[7:1]};
  assign rx_done    = rx_run && !tx_busy_q && last_bit;
  assign pop        = acc && !wb_we_i && hit(wb_adr_i, OFF_RX_FIFO) && (count_q != '0);
  assign push       = rx_done && ((count_q != CNT_W'(FIFO_DEPTH)) || pop);
  assign ov_set     = rx_done && !push;

  always_ff @(posedge clk_i) begin
    if (rst_i || !rx_run)            shift_rx_q <= 9'h000;
    else if (trail_ev && !tx_busy_q) shift_rx_q <= shift_rx_d;
  end

  always_ff @(posedge clk_i) begin
    if (push) fifo_q[wr_ptr_q] <= shift_rx_d;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en_q) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) wr_ptr_q <= (wr_ptr_q == PTR_W'(FIFO_DEPTH-1)) ? '0 : wr_ptr_q + 1'b1;
      if (pop)  rd_ptr_q <= (rd_ptr_q == PTR_W'(FIFO_DEPTH-1)) ? '0 : rd_ptr_q + 1'b1;
      if (push && !pop)      count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end

  // the set wins over any clear arriving in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || !port_en_q) begin
      overrun_error_flag_q       <= 1'b0;
      ovr_single_q <= 1'b0;
    end else if (ov_set) begin
      overrun_error_flag_q       <= 1'b1;
      ovr_single_q <= !crx_en_q;
    end else if (overrun_error_flag_q && (ovr_single_q ? pop : !crx_en_q)) begin
      overrun_error_flag_q       <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // read back
  // ---------------------------------------------------------------
  logic ninth_top;
  assign ninth_top = (count_q != '0) && fifo_q[rd_ptr_q][8];

  always_comb begin
    rd_d = 32'h0000_0000;
    if (hit(wb_adr_i, OFF_RCV_STAT)) begin
      rd_d[7:0] = {port_en_q, rx_nine_q, srx_en_q, crx_en_q, 2'b00, overrun_error_flag_q, ninth_top};
    end else if (hit(wb_adr_i, OFF_TX_STAT)) begin
      rd_d[7:0] = {clk_master_q, tx_nine_q, tx_en_q, sync_mode_q, 1'b0, high_speed_q,
                   !tx_busy_q, tx_ninth_q};
    end else if (hit(wb_adr_i, OFF_BAUD_POL)) begin
      rd_d[7:0] = {2'b00, data_inv_q, clk_idle_q, wide_div_q, 3'b000};
    end else if (hit(wb_adr_i, OFF_DIV_HI)) begin
      rd_d[7:0] = div_hi_q;
    end else if (hit(wb_adr_i, OFF_DIV_LO)) begin
      rd_d[7:0] = div_lo_q;
    end else if (hit(wb_adr_i, OFF_RX_FIFO)) begin
      rd_d[7:0] = (count_q != '0) ? fifo_q[rd_ptr_q][7:0] : 8'h00;
    end else if (hit(wb_adr_i, OFF_FLAGS)) begin
      rd_d[FL_RX_PENDING] = (count_q != '0);
      rd_d[FL_TX_EMPTY]   = !hold_full_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)    rd_q <= 32'h0000_0000;
    else if (acc) rd_q <= wb_we_i ? 32'h0000_0000 : rd_d;
  end

  assign wb_dat_o = rd_q;
  assign wb_ack_o = ack_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_clock_driven: assert property (master && half_tick |=> ck_line_oe_o && $changed(ck_line_o))
    else $error("clock line not driven in master mode");
  chk_idle_level: assert property (master && !mst_run |=> ck_line_o == clk_idle_q)
    else $error("clock line not at idle level");
  chk_half_duplex: assert property (dt_line_oe_o |-> tx_dir && !rx_run)
    else $error("data line driven while receiving");
  chk_load_now: assert property (tx_load && !hold_wr |=> tx_busy_q && !hold_full_q)
    else $error("holding register not moved to shifter");
  chk_tx_gated: assert property ($rose(tx_busy_q) |-> $past(tx_go) && $past(hold_full_q))
    else $error("transmit started without enable");
  chk_bit_lead: assert property ($changed(dout_q) |-> $past(lead_ev))
    else $error("transmit bit changed off leading edge");
  chk_bit_bound: assert property (bitcnt_q < char_bits || !(tx_busy_q || rx_run))
    else $error("too many clocks for one character");
  chk_single_end: assert property (rx_done && srx_en_q && !wr_lo |=> !srx_en_q)
    else $error("single receive did not clear");
  chk_fifo_keep: assert property (ov_set |=> overrun_error_flag_q && count_q == CNT_W'(FIFO_DEPTH))
    else $error("overrun did not keep fifo");
  chk_pending: assert property (push && !wr_lo |=> count_q != '0)
    else $error("receive pending not raised");
  chk_ovr_clear: assert property (overrun_error_flag_q && ovr_single_q && pop && !ov_set |=> !overrun_error_flag_q)
    else $error("single mode overrun not cleared by read");

  cov_tx_char:  cover property (tx_busy_q && last_bit);
  cov_rx_char:  cover property (push);
  cov_overrun:  cover property (ov_set);
  cov_abort:    cover property (bitcnt_q != 4'h0 && $fell(crx_en_q));
endmodule : ssm_port

`default_nettype wire

// ==== tb/ssm_slave_model.sv ====
// Purpose: behavioural slave device at the far end of the serial link
// Assumes: the port or the bench drives the clock line; idle_pol_i gives its idle level
// Notes:   a released data line shows the inverse of its last bit
`timescale 1ns/1ps
`default_nettype none

module ssm_slave_model (
  input  wire logic        ck_i,
  input  wire logic        dt_i,
  input  wire logic        idle_pol_i,
  input  wire logic        drive_i,
  input  wire logic        load_i,
  input  wire logic [31:0] stream_i,
  output logic             dt_o,
  output logic [31:0]      got_o,
  output logic [5:0]       n_trail_o
);
  logic [31:0] stream_q;
  logic        bit_q = 1'b0;

  // ---------------------------------------------------------------
  // shift on the link clock
  // ---------------------------------------------------------------
  always @(ck_i or posedge load_i) begin
    if (load_i) begin
      stream_q = stream_i;
      got_o = 32'h0;
      n_trail_o = 6'h00;
    end else if (ck_i === ~idle_pol_i) begin
      bit_q = stream_q[0];
      stream_q = stream_q >> 1;
    end else if (ck_i === idle_pol_i) begin
      got_o = {dt_i, got_o[31:1]};
      n_trail_o = n_trail_o + 6'h01;
    end
  end

  // released line must not hold a stale bit
  assign dt_o = drive_i ? bit_q : ~bit_q;

endmodule : ssm_slave_model
`default_nettype wire

// ==== tb/sync_serial_master_port_bench.sv ====
// Purpose: self-checking bench for the synchronous serial master port
// Assumes: master mode plus one slave receive, link period 8 system clocks (400 ns)
// Notes:   random data from a fixed seed, so any failure repeats
`timescale 1ns/1ps
`default_nettype none

module sync_serial_master_port_bench;
  import ssm_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [4:0]  adr = 5'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o, ck_line_o, ck_line_oe_o, dt_line_o, dt_line_oe_o;
  logic        inv = 1'b0, pol = 1'b0, nine, load = 1'b0, drive = 1'b0;
  logic        tgl = 1'b0;
  logic [31:0] stream = 32'h0, slv_got;
  logic [5:0]  n_trail;
  logic        slv_dt, ck_w, dt_w;
  logic [8:0]  d1, d2, d3, e1, e2;
  logic [7:0]  rdat, tcfg, rcfg;
  int          seed, nb, n_mismatch = 0, n_checks = 0, cycles = 0;
  logic [4:0]  offs [5] = '{OFF_RCV_STAT, OFF_TX_STAT, OFF_BAUD_POL, OFF_DIV_HI, OFF_DIV_LO};
  // an idle shifter reads back as shift idle right after reset
  logic [7:0]  rsts [5] = '{RST_RCV_STAT, RST_TX_STAT | (8'h01 << TX_SHIFT_IDLE),
                            RST_BAUD_POL, RST_DIV, RST_DIV};

  // released clock line rests at its idle level; tgl lets the bench act as far master
  assign ck_w = ck_line_oe_o ? ck_line_o : pol ^ tgl;
  assign dt_w = dt_line_oe_o ? dt_line_o : slv_dt;

  always #25 clk_i = ~clk_i;

  ssm_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .ck_line_i(ck_w), .ck_line_o(ck_line_o), .ck_line_oe_o(ck_line_oe_o), .dt_line_i(dt_w),
    .dt_line_o(dt_line_o), .dt_line_oe_o(dt_line_oe_o));

  ssm_slave_model u_slave (.ck_i(ck_w), .dt_i(dt_w), .idle_pol_i(pol), .drive_i(drive),
    .load_i(load), .stream_i(stream), .dt_o(slv_dt), .got_o(slv_got), .n_trail_o(n_trail));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wb(input logic [4:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= {24'h0, d};
    // only the bench timeout ends a wait for the answer
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic poll(input logic [4:0] a, input int b);
    int n;
    n = 0;
    do begin
      wb(a, 1'b0, 8'h00);
      n++;
    end while (rdat[b] !== 1'b1 && n < 300);
    check("poll", 32'(rdat[b]), 32'h1);
  endtask : poll

  task automatic reload(input logic [31:0] s, input logic drv);
    @(posedge clk_i);
    stream <= s;
    drive <= drv;
    load <= 1'b1;
    @(posedge clk_i);
    load <= 1'b0;
  endtask : reload

  task automatic wait_bits(input int n);
    int k;
    k = 0;
    while (n_trail != 6'(n) && k < 3000) begin
      @(posedge clk_i);
      k++;
    end
    // a margin after the last edge would expose a surplus clock
    repeat (40) @(posedge clk_i);
    check("clock count", 32'(n_trail), 32'(n));
  endtask : wait_bits

  function automatic logic [31:0] pack(input logic [8:0] a, input logic [8:0] b, input int n);
    logic [31:0] m;
    m = (32'h1 << n) - 32'h1;
    return ((32'(b) & m) << n) | (32'(a) & m);
  endfunction : pack

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      test_done();
    end
  end

  initial begin
    seed = 78081;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      wb(offs[i], 1'b0, 8'h00);
      check("reset value", 32'(rdat), 32'(rsts[i]));
    end
    for (int it = 0; it < 4; it++) begin
      inv = it[0];
      pol = it[1];
      nine = it[0] ^ it[1];
      nb = nine ? 9 : 8;
      d1 = 9'($random(seed));
      d2 = (it == 0) ? 9'h1ff : 9'($random(seed));
      d3 = 9'($random(seed));
      e1 = d1 ^ {9{inv}};
      e2 = d2 ^ {9{inv}};
      tcfg = 8'h94 | (8'(nine) << TX_NINE);
      rcfg = 8'h80 | (8'(nine) << RCV_NINE);
      wb(OFF_RCV_STAT, 1'b1, 8'h00);
      wb(OFF_BAUD_POL, 1'b1, {2'b00, inv, pol, 4'h8});
      wb(OFF_DIV_LO, 1'b1, 8'h01);
      wb(OFF_DIV_HI, 1'b1, 8'h00);
      wb(OFF_TX_STAT, 1'b1, tcfg | 8'h20 | 8'(d1[8]));
      wb(OFF_RCV_STAT, 1'b1, rcfg);
      reload(32'h0, 1'b0);
      wb(OFF_TX_HOLD, 1'b1, d1[7:0]);
      wb(OFF_TX_STAT, 1'b1, tcfg | 8'h20 | 8'(d2[8]));
      wb(OFF_TX_HOLD, 1'b1, d2[7:0]);
      check("clock drive", 32'(ck_line_oe_o), 32'h1);
      check("data drive", 32'(dt_line_oe_o), 32'h1);
      wait_bits(2 * nb);
      check("tx chars", slv_got >> (32 - 2 * nb), pack(e1, e2, nb));
      check("clock idle", 32'(ck_w), 32'(pol));
      wb(OFF_TX_STAT, 1'b1, tcfg);
      reload(pack(d1, d2, nb), 1'b1);
      wb(OFF_RCV_STAT, 1'b1, rcfg | 8'h20);
      check("data released", 32'(dt_line_oe_o), 32'h0);
      wait_bits(nb);
      poll(OFF_FLAGS, FL_RX_PENDING);
      wb(OFF_RCV_STAT, 1'b0, 8'h00);
      check("single self clear", 32'(rdat[RCV_SINGLE]), 32'h0);
      if (nine) check("ninth bit", 32'(rdat[RCV_NINTH]), 32'(e1[8]));
      wb(OFF_RX_FIFO, 1'b0, 8'h00);
      check("rx char", 32'(rdat), 32'(e1[7:0]));
      reload(pack(d1, d2, nb) | (32'(d3) << (2 * nb)), 1'b1);
      wb(OFF_RCV_STAT, 1'b1, rcfg | 8'h10);
      poll(OFF_RCV_STAT, RCV_OVERRUN);
      wb(OFF_RCV_STAT, 1'b1, rcfg);
      repeat (3) @(posedge clk_i);
      check("clock stopped", 32'(ck_w), 32'(pol));
      wb(OFF_RCV_STAT, 1'b0, 8'h00);
      check("overrun clear", 32'(rdat[RCV_OVERRUN]), 32'h0);
      if (nine) check("ninth first", 32'(rdat[RCV_NINTH]), 32'(e1[8]));
      wb(OFF_RX_FIFO, 1'b0, 8'h00);
      check("kept first", 32'(rdat), 32'(e1[7:0]));
      wb(OFF_RCV_STAT, 1'b0, 8'h00);
      if (nine) check("ninth second", 32'(rdat[RCV_NINTH]), 32'(e2[8]));
      wb(OFF_RX_FIFO, 1'b0, 8'h00);
      check("kept second", 32'(rdat), 32'(e2[7:0]));
      wb(OFF_FLAGS, 1'b0, 8'h00);
      check("pending gone", 32'(rdat[FL_RX_PENDING]), 32'h0);
    end
    // slave receive: the bench plays the far master, one clock per bit
    wb(OFF_RCV_STAT, 1'b1, 8'h00);
    wb(OFF_TX_STAT, 1'b1, 8'h10);
    reload({23'h0, d3}, 1'b1);
    wb(OFF_RCV_STAT, 1'b1, 8'h90);
    repeat (16) begin
      repeat (4) @(posedge clk_i);
      tgl <= ~tgl;
    end
    repeat (10) @(posedge clk_i);
    check("clock released", 32'(ck_line_oe_o), 32'h0);
    wb(OFF_RX_FIFO, 1'b0, 8'h00);
    check("slave rx char", 32'(rdat), 32'(d3[7:0] ^ {8{inv}}));
    test_done();
  end

endmodule : sync_serial_master_port_bench
`default_nettype wire
